/* logic/cvw_irq_ctrl.sv */
// Chained vectored interrupt controller with wake-up request folding.
//
// What this block does
// - Primary unit always outranks the secondary unit.
// - Hardware resolves priority; reader gets source, vector.
// - Reserved cache entry holds the vector-fetch instruction.
// - Thirty-two channels: five wake-up, twenty-seven internal.
// - Firmware can force a request on any channel.
// - Channel 25 ORs all thirty-two wake-up inputs.
// - Only selected, enabled pins count; any wakes.
// - Channels 25..31 sit on secondary inputs 9..15.
// - Channel 26 ORs timer, resume, port-3 pins 2..7.
// - Channels 27..29 OR ports 5, 6, 7 pins.
// - Channel 30 carries bus resume, also a wake input.
// - Channel 31 is lowest, for prefetch and cache.
// - Normal request ORs all channels not on fast; 0 highest.
// - Any source may go to fast request, which wins.
// - Firmware remaps sources to slots within one unit.
`timescale 1ns/1ps
`include "cvw_irq_map.svh"

module cvw_irq_ctrl (
  input  wire logic        clk_sys_in,
  input  wire logic        resetn_in,
  input  wire logic [24:0] periph_irq_in,
  input  wire logic        prefetch_cache_irq_in,
  input  wire logic [29:0] wake_pin_in,
  input  wire logic [29:0] wake_pin_en_in,
  input  wire logic        rtc_irq_in,
  input  wire logic        bus_resume_in,
  input  wire logic [31:0] force_in,
  input  wire logic [31:0] enable_in,
  input  wire logic [31:0] fast_sel_in,
  input  wire logic [127:0] slot_src_in,
  input  wire logic [31:0] vec_base_in,
  input  wire logic        read_vec_in,
  input  wire logic        cache_load_in,
  input  wire logic [31:0] cache_tag_in,
  input  wire logic [31:0] cache_insn_in,
  input  wire logic        fetch_in,
  input  wire logic [31:0] fetch_addr_in,
  output logic             irq_out,
  output logic             fast_irq_out,
  output logic             wakeup_out,
  output logic             vec_valid_out,
  output logic             vec_none_out,
  output logic [4:0]       vec_chan_out,
  output logic [4:0]       vec_src_out,
  output logic [31:0]      vec_addr_out,
  output logic             cache_hit_out,
  output logic [31:0]      cache_data_out
);

  //--------------------------------------------------------------
  // State and decoded request vectors
  //--------------------------------------------------------------
  cvw_irq_pkg::cvw_state_t st_r;
  cvw_irq_pkg::cvw_state_t st_nxt;
  logic [31:0] wake_act;
  logic [31:0] src_vec;
  logic [31:0] eff_vec;
  logic [31:0] hw_req;
  logic [4:0]  hw_src [32];
  logic [4:0]  win_chan;
  logic        win_any;

  //--------------------------------------------------------------
  // Wake-up folding
  //--------------------------------------------------------------
  // Pins count only when selected; the timer and resume always count.
  assign wake_act = {st_r.sync2[`CVW_WK_BUS_RES],
                     st_r.sync2[`CVW_WK_RTC],
                     st_r.sync2[29:0] & wake_pin_en_in};

  // Source vector: internal sources plus the five wake-up groups.
  always_comb begin
    src_vec                     = '0;
    src_vec[24:0]               = periph_irq_in;
    src_vec[`CVW_SRC_WAKE_ALL]  = |wake_act;
    src_vec[`CVW_SRC_GRP0]      = wake_act[`CVW_WK_RTC]
                                | wake_act[`CVW_WK_BUS_RES]
                                | (|wake_act[5:0]);
    src_vec[`CVW_SRC_GRP1]      = |wake_act[13:6];
    src_vec[`CVW_SRC_GRP2]      = |wake_act[21:14];
    src_vec[`CVW_SRC_GRP3]      = |wake_act[29:22];
    src_vec[`CVW_SRC_BUS_RES]   = st_r.sync2[`CVW_WK_BUS_RES];
    src_vec[`CVW_SRC_PREFETCH]  = prefetch_cache_irq_in;
  end

  // Forced requests join the source before the enable gate.
  assign eff_vec = (src_vec | force_in) & enable_in;

  //--------------------------------------------------------------
  // Slot mapping and priority
  //--------------------------------------------------------------
  // Each slot picks a source of its own unit only, so remapping
  // never moves a source across the chain boundary.
  always_comb begin
    for (int c = 0; c < `CVW_NUM_CH; c++) begin
      hw_src[c] = {c[4], slot_src_in[4*c +: 4]};
      hw_req[c] = eff_vec[hw_src[c]] & ~fast_sel_in[hw_src[c]];
    end
  end

  // Lowest slot wins; primary slots 0..15 precede secondary ones.
  always_comb begin
    win_chan = `CVW_RST_CH;
    win_any  = 1'b0;
    for (int c = `CVW_NUM_CH - 1; c >= 0; c--) begin
      if (hw_req[c]) begin
        win_chan = 5'(c);
        win_any  = 1'b1;
      end
    end
  end

  //--------------------------------------------------------------
  // Next state
  //--------------------------------------------------------------
  always_comb begin
    st_nxt       = st_r;
    st_nxt.sync1 = {bus_resume_in, rtc_irq_in, wake_pin_in};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.irq   = |hw_req;
    st_nxt.fast  = |(eff_vec & fast_sel_in);
    st_nxt.wake  = |wake_act;
    st_nxt.vec_valid = read_vec_in;
    // A read captures the winner at the moment of the access.
    if (read_vec_in) begin
      st_nxt.vec_none = ~win_any;
      st_nxt.vec_chan = win_chan;
      st_nxt.vec_src  = hw_src[win_chan];
      st_nxt.vec_addr = vec_base_in + {25'h0, win_chan, 2'h0};
    end
    // The reserved entry is never evicted by ordinary fills.
    if (cache_load_in) begin
      st_nxt.ent_tag  = cache_tag_in;
      st_nxt.ent_insn = cache_insn_in;
      st_nxt.ent_full = 1'b1;
    end
    st_nxt.ent_hit = fetch_in & st_r.ent_full
                   & (fetch_addr_in == st_r.ent_tag);
    if (st_nxt.ent_hit) begin
      st_nxt.ent_data = st_r.ent_insn;
    end
  end

  //--------------------------------------------------------------
  // State register
  //--------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign irq_out       = st_r.irq;
  assign fast_irq_out  = st_r.fast;
  assign wakeup_out    = st_r.wake;
  assign vec_valid_out = st_r.vec_valid;
  assign vec_none_out  = st_r.vec_none;
  assign vec_chan_out  = st_r.vec_chan;
  assign vec_src_out   = st_r.vec_src;
  assign vec_addr_out  = st_r.vec_addr;
  assign cache_hit_out  = st_r.ent_hit;
  assign cache_data_out = st_r.ent_data;

  //--------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  property p_primary_first;
    read_vec_in && (|hw_req[15:0]) |=> !vec_chan_out[4];
  endproperty
  a_primary_first: assert property (p_primary_first)
    else $error("Secondary channel won over a primary request.");

  property p_vec_read;
    read_vec_in && win_any |=> vec_valid_out && !vec_none_out
      && vec_addr_out == $past(vec_base_in)
         + {25'h0, vec_chan_out, 2'h0};
  endproperty
  a_vec_read: assert property (p_vec_read)
    else $error("Vector read returned a wrong address.");

  property p_entry_hit;
    cache_load_in ##1 (fetch_in && fetch_addr_in == $past(cache_tag_in)
      && !cache_load_in) |=> cache_hit_out
      && cache_data_out == $past(cache_insn_in, 2);
  endproperty
  a_entry_hit: assert property (p_entry_hit)
    else $error("Reserved cache entry missed its instruction.");

  property p_force;
    (|(force_in & enable_in & ~fast_sel_in)) |=> irq_out;
  endproperty
  a_force: assert property (p_force)
    else $error("Forced request did not raise the normal request.");

  property p_wake_pin;
    wake_pin_in[0] && wake_pin_en_in[0] ##1 wake_pin_in[0]
      && wake_pin_en_in[0] ##1 wake_pin_en_in[0] |-> src_vec[25]
      && src_vec[26] ##1 wakeup_out;
  endproperty
  a_wake_pin: assert property (p_wake_pin)
    else $error("Held wake pin failed to reach the wake channels.");

  property p_pin_gate;
    wake_pin_en_in == 30'h0 && !st_r.sync2[30] && !st_r.sync2[31]
      |-> !src_vec[25] && src_vec[29:26] == 4'h0;
  endproperty
  a_pin_gate: assert property (p_pin_gate)
    else $error("Disabled wake pin raised a request.");

  property p_lowest;
    read_vec_in && hw_req == 32'h8000_0000 |=> vec_chan_out == 5'h1F;
  endproperty
  a_lowest: assert property (p_lowest)
    else $error("Lone lowest request resolved to another slot.");

  property p_top;
    read_vec_in && hw_req[0] |=> vec_chan_out == 5'h00;
  endproperty
  a_top: assert property (p_top)
    else $error("Slot zero did not win.");

  property p_fast;
    (|(eff_vec & fast_sel_in)) && !(|(eff_vec & ~fast_sel_in))
      |=> fast_irq_out && !irq_out;
  endproperty
  a_fast: assert property (p_fast)
    else $error("Fast-selected source reached the wrong output.");

  property p_gate;
    enable_in == 32'h0 |=> !irq_out && !fast_irq_out;
  endproperty
  a_gate: assert property (p_gate)
    else $error("Disabled sources still raised a request.");

  // Reads with nothing pending report the empty case at the base.
  property p_none;
    read_vec_in && !win_any |=> vec_valid_out && vec_none_out
      && vec_chan_out == 5'h00 && vec_addr_out == $past(vec_base_in);
  endproperty
  a_none: assert property (p_none)
    else $error("Empty vector read did not report the empty case.");

  // The valid strobe must not linger past the read that caused it.
  property p_valid_pulse;
    !read_vec_in |=> !vec_valid_out;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse)
    else $error("Vector valid stood without a read.");

  // A forced source that is steered to the fast line must raise it.
  property p_fast_force;
    (|(force_in & enable_in & fast_sel_in)) |=> fast_irq_out;
  endproperty
  a_fast_force: assert property (p_fast_force)
    else $error("Forced fast source did not raise the fast request.");

  //--------------------------------------------------------------
  // Wake-up group timing: two synchroniser edges, then the group
  //--------------------------------------------------------------
  // Each port-pin check takes the pin two edges back and the select now,
  // because the select is a same-clock level and the pin is not.
  property p_timer_group;
    rtc_irq_in |-> ##2 src_vec[26] && src_vec[25];
  endproperty
  a_timer_group: assert property (p_timer_group)
    else $error("Timer wake input missed group zero.");

  property p_port5_group;
    wake_pin_in[13] ##2 wake_pin_en_in[13] |-> src_vec[27];
  endproperty
  a_port5_group: assert property (p_port5_group)
    else $error("Port five pin missed its group channel.");

  property p_port6_group;
    wake_pin_in[14] ##2 wake_pin_en_in[14] |-> src_vec[28];
  endproperty
  a_port6_group: assert property (p_port6_group)
    else $error("Port six pin missed its group channel.");

  property p_port7_group;
    wake_pin_in[29] ##2 wake_pin_en_in[29] |-> src_vec[29];
  endproperty
  a_port7_group: assert property (p_port7_group)
    else $error("Port seven pin missed its group channel.");

  property p_resume;
    bus_resume_in |-> ##2 src_vec[30] && src_vec[25] && src_vec[26];
  endproperty
  a_resume: assert property (p_resume)
    else $error("Bus resume missed its own channel or the wake groups.");

  // Main scenarios that the bench is expected to reach.
  c_read: cover property (read_vec_in && win_any ##1 vec_valid_out);
  c_fast: cover property (fast_irq_out && irq_out);
  c_wake: cover property (wakeup_out);
  c_hit: cover property (cache_hit_out);
  c_none: cover property (read_vec_in && !win_any);

endmodule : cvw_irq_ctrl

/* shared/cvw_irq_map.svh */
// Constants for the chained vectored interrupt and wake-up block.
`ifndef CVW_IRQ_MAP_SVH
`define CVW_IRQ_MAP_SVH

// Channel counts and unit split.
`define CVW_NUM_CH        32
`define CVW_UNIT_CH       16
`define CVW_NUM_PERIPH    25
`define CVW_NUM_PINS      30

// Source positions inside the 32-entry source vector.
`define CVW_SRC_WAKE_ALL  25
`define CVW_SRC_GRP0      26
`define CVW_SRC_GRP1      27
`define CVW_SRC_GRP2      28
`define CVW_SRC_GRP3      29
`define CVW_SRC_BUS_RES   30
`define CVW_SRC_PREFETCH  31

// Wake-up input positions: pins 0..29, then timer and bus resume.
`define CVW_WK_GRP0_PIN_LO 0
`define CVW_WK_GRP1_LO     6
`define CVW_WK_GRP2_LO     14
`define CVW_WK_GRP3_LO     22
`define CVW_WK_RTC         30
`define CVW_WK_BUS_RES     31

// Reset values.
`define CVW_RST_W32       32'h0000_0000
`define CVW_RST_CH        5'h00

`endif

/* shared/cvw_irq_pkg.sv */
// Types for the chained vectored interrupt and wake-up block.
package cvw_irq_pkg;

  // All registered state of the controller.
  typedef struct packed {
    logic [31:0] sync1;
    logic [31:0] sync2;
    logic        irq;
    logic        fast;
    logic        wake;
    logic        vec_valid;
    logic        vec_none;
    logic [4:0]  vec_chan;
    logic [4:0]  vec_src;
    logic [31:0] vec_addr;
    logic [31:0] ent_tag;
    logic [31:0] ent_insn;
    logic        ent_full;
    logic        ent_hit;
    logic [31:0] ent_data;
  } cvw_state_t;

endpackage : cvw_irq_pkg

/* testbench/cvw_core_model.sv */
// Processor core model that answers a serve request from the bench by reading the vector.
`timescale 1ns/1ps
module cvw_core_model (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic serve_in,
  output logic      read_vec_out
);
  // The service routine reads the controller one cycle after it is told to.
  // The pulse is launched just after the edge so the design samples it clean.
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) read_vec_out <= 1'b0;
    else read_vec_out <= #1 serve_in;
  end
endmodule : cvw_core_model

/* testbench/cvw_irq_ctrl_tb_top.sv */
// Self-checking bench for the chained vectored interrupt controller.
`timescale 1ns/1ps
module cvw_irq_ctrl_tb_top;
  logic clk_sys_in = 1'b0, resetn_in = 1'b0, pcr, rtc, bres, rd, cld, fet;
  logic serve, irq, fst, wk, vv, vn, hit;
  logic [24:0] per;
  logic [29:0] pin, pen;
  logic [31:0] frc, en, fs, base, tag, insn, fa, va, bd, seed = 32'hBF97ED5B;
  logic [127:0] slot;
  logic [4:0] ch, sr;
  int fails = 0, samples_checked = 0;

  always #12.5 clk_sys_in = ~clk_sys_in;

  cvw_irq_ctrl dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .periph_irq_in(per), .prefetch_cache_irq_in(pcr), .wake_pin_in(pin),
    .wake_pin_en_in(pen), .rtc_irq_in(rtc), .bus_resume_in(bres),
    .force_in(frc), .enable_in(en), .fast_sel_in(fs), .slot_src_in(slot),
    .vec_base_in(base), .read_vec_in(rd), .cache_load_in(cld),
    .cache_tag_in(tag), .cache_insn_in(insn), .fetch_in(fet),
    .fetch_addr_in(fa), .irq_out(irq), .fast_irq_out(fst),
    .wakeup_out(wk), .vec_valid_out(vv), .vec_none_out(vn),
    .vec_chan_out(ch), .vec_src_out(sr), .vec_addr_out(va),
    .cache_hit_out(hit), .cache_data_out(bd));
  cvw_core_model core (.clk_in(clk_sys_in), .resetn_in(resetn_in),
    .serve_in(serve), .read_vec_out(rd));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // Reference model: fold wake inputs, gate, then lowest slot wins.
  task automatic check_all();
    logic [29:0] g;
    logic [31:0] src, eff, nrm;
    int win, c, i;
    g = pin & pen;
    src = {pcr, bres, |g[29:22], |g[21:14], |g[13:6],
           (|g[5:0]) | rtc | bres, (|g) | rtc | bres, per};
    eff = (src | frc) & en;
    nrm = eff & ~fs;
    chk("irq", irq, {31'h0, |nrm});
    chk("fast", fst, {31'h0, |(eff & fs)});
    chk("wake", wk, {31'h0, (|g) | rtc | bres});
    win = -1;
    for (c = 31; c >= 0; c--) if (nrm[{c[4], slot[4*c+:4]}]) win = c;
    serve = 1'b1;
    @(posedge clk_sys_in) #1 serve = 1'b0;
    for (i = 0; i < 6 && vv !== 1'b1; i++) @(posedge clk_sys_in) #1;
    chk("valid", {31'h0, vv}, 32'h1);
    chk("none", {31'h0, vn}, {31'h0, win < 0});
    if (win < 0) win = 0;
    else chk("src", {27'h0, sr}, {27'h0, win[4], slot[4*win+:4]});
    chk("chan", {27'h0, ch}, win);
    chk("addr", va, base + win * 4);
  endtask : check_all

  // Wake inputs are held for four edges so the synchroniser has settled.
  initial begin
    {per, pcr, rtc, bres, cld, fet, serve, pin, pen} = '0;
    {frc, en, fs, tag, insn, fa, slot} = '0;
    base = 32'h0000_1000;
    repeat (2) @(posedge clk_sys_in);
    #1 resetn_in = 1'b1;
    chk("rst", {28'h0, vv, vn, irq, hit}, 32'h0);
    tag = rnd();
    insn = rnd();
    fa = tag;
    fet = 1'b1;
    @(posedge clk_sys_in) #1 fet = 1'b0;
    chk("entry_early", {31'h0, hit}, 32'h0);
    cld = 1'b1;
    @(posedge clk_sys_in) #1 {cld, fet} = 2'b01;
    @(posedge clk_sys_in) #1 {fet, fa} = {1'b1, ~tag};
    chk("entry_hit", {31'h0, hit}, 32'h1);
    chk("entry_data", bd, insn);
    @(posedge clk_sys_in) #1 fet = 1'b0;
    chk("entry_miss", {31'h0, hit}, 32'h0);
    // Sparse random sources, per-unit slot permutations, random forces.
    for (int n = 0; n < 300; n++) begin
      logic [31:0] r, k;
      r = rnd();
      k = rnd();
      per = 25'(rnd() & rnd() & rnd());
      {pcr, rtc, bres} = {r[4], r[0] & r[1], r[2] & r[3]};
      pin = 30'(rnd());
      pen = 30'(rnd() & rnd() & rnd() & rnd());
      frc = rnd() & rnd() & rnd() & rnd() & rnd();
      en = rnd() | rnd();
      fs = rnd() & rnd() & rnd() & rnd();
      base = {rnd() & 32'hFFFF_FFFC};
      for (int c = 0; c < 32; c++)
        slot[4*c+:4] = c[3:0] ^ (c[4] ? k[7:4] : k[3:0]);
      repeat (4) @(posedge clk_sys_in);
      #1 check_all();
    end
    // Ends of the priority range: a lone lowest source, then none.
    for (int n = 0; n < 2; n++) begin
      {per, rtc, bres, pin, pen, frc, fs} = '0;
      pcr = (n == 0);
      en = 32'hFFFF_FFFF;
      for (int c = 0; c < 32; c++) slot[4*c+:4] = c[3:0];
      repeat (4) @(posedge clk_sys_in);
      #1 check_all();
    end
    summarize();
  end

  // Watchdog sized well beyond the expected run of under two thousand cycles.
  initial begin
    #(25 * 20000);
    fails++;
    summarize();
  end
endmodule : cvw_irq_ctrl_tb_top
